// File: design/bid_bemf_detect.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module bid_bemf_detect #(
  parameter int UNIT_CYC = bid_pkg::US_CYC
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [7:0]        awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [7:0]        araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // motor side pins
  input  wire logic              phase_input_a,
  input  wire logic              phase_input_b,
  input  wire logic              phase_input_c,
  input  wire logic              comp_out,
  // analog front end control
  output bid_pkg::bid_afe_s      afe,
  // delay manager and pwm side
  input  wire logic              comm_hw,
  input  wire logic              sim_demag,
  input  wire logic              mwin_strobe,
  input  wire logic              pwm_strobe,
  output logic [3:0]             mwin_rate,
  output logic                   demag_event,
  output logic                   zero_event,
  output logic                   speed_input,
  output logic [2:0]             hall_state
);
  import bid_pkg::*;

  bid_ctrl_s   ctrl_ff;
  bid_cfg_s    cfg_ff;
  bid_afe_s    afe_ff;
  bid_state_e  st_ff;
  bid_mode_e   mode;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [3:0]  cmd_ff;
  logic [3:0]  s1_ff;
  logic [3:0]  s2_ff;
  logic [3:0]  s3_ff;
  logic [3:0]  filt_ff;
  logic [3:0]  run_ff;
  logic        demag_flag_ff;
  logic        zero_flag_ff;
  logic        demag_ev_ff;
  logic        zero_ev_ff;
  logic        speed_ff;
  logic [2:0]  hall_ff;
  logic        do_write;
  logic        comp_en;
  logic        det_en;
  logic        c_evt;
  logic        sim_d;
  logic        d_tick;
  logic        z_tick;
  logic        cmp;
  logic        d_level;
  logic        z_level;
  logic        d_cond;
  logic        z_cond;
  logic [3:0]  limit;
  logic        d_hit;
  logic        z_hit;
  logic        order_on;
  logic        blank_load;
  logic        blank_busy;
  logic        blank_done;
  logic        sel_in;

  // write channel handshakes
  assign awready  = !aw_got_ff && !bvalid_ff;
  assign wready   = !w_got_ff && !bvalid_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= awaddr;
      end else if (do_write) begin
        aw_got_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end else if (do_write) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (aw_addr_ff[7:2] > ADDR_STAT[7:2]) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;

  // control and configuration registers
  // window field reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      cfg_ff  <= CFG_RST;
    end else if (do_write && aw_addr_ff[7:2] == ADDR_CTRL[7:2]) begin
      ctrl_ff <= 8'(wmerge(32'(ctrl_ff), w_data_ff, w_strb_ff));
    end else if (do_write && aw_addr_ff[7:2] == ADDR_CFG[7:2]) begin
      cfg_ff <= 23'(wmerge(32'(cfg_ff), w_data_ff, w_strb_ff));
    end
  end

  // command pulses, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ff <= 4'h0;
    end else if (do_write && aw_addr_ff[7:2] == ADDR_CMD[7:2] && w_strb_ff[0]) begin
      cmd_ff <= w_data_ff[3:0];
    end else begin
      cmd_ff <= 4'h0;
    end
  end

  // read channel
  assign arready = !rvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      case (araddr[7:2])
        ADDR_CTRL[7:2]: rdata_ff <= 32'(ctrl_ff);
        ADDR_CFG[7:2]:  rdata_ff <= 32'(cfg_ff);
        ADDR_CMD[7:2]:  rdata_ff <= 32'h00000000;
        ADDR_STAT[7:2]: rdata_ff <= {17'h00000, cmp, filt_ff[2:0], run_ff, mode,
                                     comp_en, blank_busy, zero_flag_ff, demag_flag_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

  // pin synchronisers, change taken when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff   <= 4'h0;
      s2_ff   <= 4'h0;
      s3_ff   <= 4'h0;
      filt_ff <= 4'h0;
    end else begin
      s1_ff   <= {comp_out, phase_input_c, phase_input_b, phase_input_a};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
    end
  end

  // operating mode
  // mode select
  always_comb begin
    if (cfg_ff.sensor_type_field != TYPE_POSITION) begin
      mode = MODE_SPEED;
    end else if (ctrl_ff.sensor_select_bit) begin
      mode = MODE_SENSOR;
    end else begin
      mode = MODE_SENSORLESS;
    end
  end

  // one phase input picked
  // input steering
  always_comb begin
    case (cfg_ff.input_select_field)
      2'h1:    sel_in = filt_ff[1];
      2'h2:    sel_in = filt_ff[2];
      default: sel_in = filt_ff[0];
    endcase
  end

  assign comp_en = ctrl_ff.clk_enable || ctrl_ff.ref_enable;
  assign det_en  = comp_en && (mode != MODE_SPEED);

  // analog front end settings
  // reference select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afe_ff <= '0;
    end else begin
      afe_ff.comp_enable <= comp_en;
      afe_ff.ext_ref_sel <= (cfg_ff.threshold_select_field == 3'h7);
      afe_ff.ref_code    <= cfg_ff.threshold_select_field;
      afe_ff.mux_sel     <= cfg_ff.input_select_field;
    end
  end

  assign afe       = afe_ff;
  assign mwin_rate = cfg_ff.window_rate_field;

  // digital and hall outputs by mode
  // input use by mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ff <= 1'b0;
      hall_ff  <= 3'h0;
    end else begin
      speed_ff <= (mode == MODE_SPEED) && sel_in;
      hall_ff  <= (mode == MODE_SENSOR) ? filt_ff[2:0] : 3'h0;
    end
  end

  assign speed_input = speed_ff;
  assign hall_state  = hall_ff;

  // event sources and sample pacing
  assign c_evt = det_en && (comm_hw || cmd_ff[0]);
  assign sim_d = sim_demag || cmd_ff[1];
  assign z_tick = ctrl_ff.voltage_mode ? pwm_strobe : mwin_strobe;

  bid_tick_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (cfg_ff.sample_div),
    .tick    (d_tick)
  );

  assign blank_load = c_evt && (mode == MODE_SENSORLESS);

  bid_blank_timer #(.UNIT_CYC(UNIT_CYC)) u_blank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (blank_load),
    .code    (cfg_ff.demag_window_field),
    .busy    (blank_busy),
    .done    (blank_done)
  );

  // edge classification on the comparator level
  // edge polarity
  assign cmp     = filt_ff[3];
  assign d_level = !ctrl_ff.edge_polarity_bit;
  assign z_level = ctrl_ff.level_edge_select_bit ? d_level : ctrl_ff.edge_polarity_bit;
  assign d_cond  = (cmp == d_level);
  assign z_cond  = (cmp == z_level);

  assign limit = ctrl_ff.sensor_select_bit ? 4'h0 : cfg_ff.demag_count_field;

  assign d_hit = det_en && !c_evt && (st_ff == ST_DCNT)
               && (sim_d || (d_tick && d_cond && run_ff == limit));

  assign order_on = ctrl_ff.autoswitch && ctrl_ff.hard_comm;
  assign z_hit    = det_en && !c_evt && z_tick && z_cond
                  && (order_on ? (st_ff == ST_ZARM) : (st_ff != ST_BLANK));

  // sequencer: commutation, blanking, demag count, zero arm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_WAIT_C;
    end else if (!det_en) begin
      st_ff <= ST_WAIT_C;
    end else if (c_evt) begin
      st_ff <= (mode == MODE_SENSOR) ? ST_DCNT : ST_BLANK;
    end else begin
      case (st_ff)
        ST_WAIT_C: st_ff <= ST_WAIT_C;
        ST_BLANK:  st_ff <= blank_done ? ST_DCNT : ST_BLANK;
        ST_DCNT:   st_ff <= d_hit ? ST_ZARM : ST_DCNT;
        ST_ZARM:   st_ff <= z_hit ? ST_WAIT_C : ST_ZARM;
        default:   st_ff <= ST_WAIT_C;
      endcase
    end
  end

  // consecutive detection counter
  // restart on miss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 4'h0;
    end else if (st_ff != ST_DCNT || c_evt || d_hit) begin
      run_ff <= 4'h0;
    end else if (d_tick) begin
      run_ff <= d_cond ? run_ff + 4'h1 : 4'h0;
    end
  end

  // sticky flags, a set beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demag_flag_ff <= 1'b0;
      zero_flag_ff  <= 1'b0;
      demag_ev_ff   <= 1'b0;
      zero_ev_ff    <= 1'b0;
    end else begin
      demag_flag_ff <= d_hit || (demag_flag_ff && !cmd_ff[2]);
      zero_flag_ff  <= z_hit || (zero_flag_ff && !cmd_ff[3]);
      demag_ev_ff   <= d_hit;
      zero_ev_ff    <= z_hit;
    end
  end

  assign demag_event = demag_ev_ff;
  assign zero_event  = zero_ev_ff;

  property p_comp_off;
    @(posedge aclk) disable iff (!aresetn)
      !comp_en |=> !demag_event && !zero_event;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("event with comparator off");

  property p_order;
    @(posedge aclk) disable iff (!aresetn)
      (order_on && st_ff != ST_ZARM) |=> !zero_event;
  endproperty
  a_order: assert property (p_order) else $error("zero crossing out of order");

  property p_blank_start;
    @(posedge aclk) disable iff (!aresetn)
      (c_evt && mode == MODE_SENSORLESS) |=> (st_ff == ST_BLANK) && blank_busy;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("no blanking after commutation");

  property p_no_blank;
    @(posedge aclk) disable iff (!aresetn)
      (c_evt && mode == MODE_SENSOR) |=> (st_ff == ST_DCNT) && !blank_busy;
  endproperty
  a_no_blank: assert property (p_no_blank) else $error("blanking in sensor mode");

  property p_limit;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff == ST_DCNT && det_en && !c_evt && d_tick && d_cond && run_ff == limit)
        |=> demag_flag_ff && (st_ff == ST_ZARM) ##1 !demag_event;
  endproperty
  a_limit: assert property (p_limit) else $error("demag limit not honoured");

  property p_run_restart;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff == ST_DCNT && d_tick && !d_cond) |=> (run_ff == 4'h0);
  endproperty
  a_run_restart: assert property (p_run_restart) else $error("counter kept on miss");

  property p_sim_demag;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff == ST_DCNT && det_en && !c_evt && sim_d) |=> demag_event;
  endproperty
  a_sim_demag: assert property (p_sim_demag) else $error("simulated demag filtered");

  property p_rst_window;
    @(posedge aclk) $rose(aresetn) |-> (cfg_ff.demag_window_field == DWIN_RST);
  endproperty
  a_rst_window: assert property (p_rst_window) else $error("window reset value wrong");

  property p_speed_mode;
    @(posedge aclk) disable iff (!aresetn)
      (cfg_ff.sensor_type_field != TYPE_POSITION) |=> !demag_event && !zero_event;
  endproperty
  a_speed_mode: assert property (p_speed_mode) else $error("detection in speed mode");
endmodule

// File: inc/bid_pkg.sv
package bid_pkg;
  // clock rate and window timing
  localparam int CLK_MHZ        = 50;
  localparam int US_CYC         = CLK_MHZ;
  localparam int WIN_STEP_US    = 5;
  localparam int WIN_HI_BASE_US = 60;
  localparam int WIN_HI_STEP_US = 20;
  localparam int CW             = 16;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_CMD  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [22:0] CFG_RST  = 23'h007800;
  localparam logic [3:0]  DWIN_RST = 4'hF;

  // encodings
  localparam logic [1:0] TYPE_POSITION = 2'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    MODE_SENSOR     = 3'b001,
    MODE_SENSORLESS = 3'b010,
    MODE_SPEED      = 3'b100
  } bid_mode_e;

  typedef enum logic [3:0] {
    ST_WAIT_C = 4'b0001,
    ST_BLANK  = 4'b0010,
    ST_DCNT   = 4'b0100,
    ST_ZARM   = 4'b1000
  } bid_state_e;

  typedef struct packed {
    logic level_edge_select_bit;
    logic edge_polarity_bit;
    logic hard_comm;
    logic autoswitch;
    logic voltage_mode;
    logic ref_enable;
    logic clk_enable;
    logic sensor_select_bit;
  } bid_ctrl_s;

  typedef struct packed {
    logic [3:0] sample_div;
    logic [3:0] demag_count_field;
    logic [3:0] demag_window_field;
    logic [3:0] window_rate_field;
    logic [2:0] threshold_select_field;
    logic [1:0] input_select_field;
    logic [1:0] sensor_type_field;
  } bid_cfg_s;

  typedef struct packed {
    logic       comp_enable;
    logic       ext_ref_sel;
    logic [2:0] ref_code;
    logic [1:0] mux_sel;
  } bid_afe_s;

  // blanking length in cycles for a window code
  // window code lengths
  function automatic logic [CW-1:0] win_cycles(input logic [3:0] code, input logic [CW-1:0] unit);
    logic [CW-1:0] us;
    us = code[3] ? CW'(WIN_HI_BASE_US + int'(code[2:0]) * WIN_HI_STEP_US)
                 : CW'((int'(code[2:0]) + 1) * WIN_STEP_US);
    return CW'(us * unit);
  endfunction

  // byte-lane merge of a bus write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// File: design/bid_tick_div.sv
`timescale 1ns/1ps
module bid_tick_div (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // divider setting and strobe
  input  wire logic [3:0] div,
  output logic            tick
);
  import bid_pkg::*;

  logic [3:0] cnt_ff;
  logic       tick_ff;

  // one strobe every div+1 cycles
  // selectable sample rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= div) begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 4'h1;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

  property p_tick_spacing;
    @(posedge aclk) disable iff (!aresetn)
      (tick_ff && div != 4'h0 && $stable(div)) |=> !tick_ff;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("sample strobe too close");
endmodule

// File: design/bid_blank_timer.sv
`timescale 1ns/1ps
module bid_blank_timer #(
  parameter int UNIT_CYC = bid_pkg::US_CYC
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // window control
  input  wire logic       load,
  input  wire logic [3:0] code,
  output logic            busy,
  output logic            done
);
  import bid_pkg::*;

  logic [CW-1:0] cnt_ff;
  logic          done_ff;

  // load window length, count down to zero
  // cycle-counted window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (load) begin
      cnt_ff  <= win_cycles(code, CW'(UNIT_CYC));
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= (cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;
      done_ff <= (cnt_ff == CW'(1));
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;

  property p_load_len;
    @(posedge aclk) disable iff (!aresetn)
      load |=> (cnt_ff == win_cycles($past(code), CW'(UNIT_CYC)));
  endproperty
  a_load_len: assert property (p_load_len) else $error("window length wrong");
endmodule

// File: tb/bid_motor_model.sv
`timescale 1ns/1ps
// motor phases and comparator on the far side of the front end
module bid_motor_model (
  // clock and drive pattern
  input  wire logic              aclk,
  input  wire logic [2:0]        lvl,
  input  wire logic              enc,
  // front end control
  input  wire bid_pkg::bid_afe_s afe,
  // phase pins and comparator
  output logic                   phase_input_a,
  output logic                   phase_input_b,
  output logic                   phase_input_c,
  output logic                   comp_out
);
  import bid_pkg::*;
  initial begin
    {phase_input_a, phase_input_b, phase_input_c, comp_out} = 4'h0;
  end
  // phases a and b follow the pattern one clock later, phase c only while enc is low
  always @(posedge aclk) begin
    phase_input_a <= lvl[0];
    phase_input_b <= lvl[1];
    phase_input_c <= enc ? 1'b0 : lvl[2];
  end
  // selected phase seen by the comparator, low while it is off
  always @(posedge aclk) begin
    comp_out <= afe.comp_enable & lvl[(afe.mux_sel == 2'h3) ? 2'h0 : afe.mux_sel];
  end
endmodule

// File: tb/tb_bid_bemf_detect.sv
`timescale 1ns/1ps
// register bus and detection sequences for the front end
module tb_bid_bemf_detect;
  import bid_pkg::*;
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, hit, enc;
  logic        comm_hw, sim_demag, mwin_strobe, pwm_strobe;
  logic        phase_input_a, phase_input_b, phase_input_c, comp_out;
  logic        demag_event, zero_event, speed_input;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb, mwin_rate;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  hall_state, lvl;
  bid_afe_s    afe;
  int          err_count, check_count, n, c, k, e, v;
  int          codes[4] = '{0, 7, 8, 15};

  bid_bemf_detect #(.UNIT_CYC(1)) u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .phase_input_a, .phase_input_b,
    .phase_input_c, .comp_out, .afe, .comm_hw, .sim_demag, .mwin_strobe, .pwm_strobe,
    .mwin_rate, .demag_event, .zero_event, .speed_input, .hall_state);
  bid_motor_model u_motor (.aclk, .lvl, .enc, .afe, .phase_input_a, .phase_input_b,
    .phase_input_c, .comp_out);

  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // watchdog
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end

  // bus write, response code left in rsp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  // bus read into rd_val
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    rsp = rresp;
  endtask
  // one-cycle strobe: 0 commutation, 1 sim demag, 2 window, 3 pwm
  task automatic pulse(input int s);
    @(posedge aclk);
    comm_hw <= (s == 0);
    sim_demag <= (s == 1);
    mwin_strobe <= (s == 2);
    pwm_strobe <= (s == 3);
    @(posedge aclk);
    {comm_hw, sim_demag, mwin_strobe, pwm_strobe} <= 4'h0;
  endtask
  // edges until demag (z=0) or zero (z=1) event, bounded
  task automatic wait_ev(input bit z, input int lim);
    n = 0;
    hit = 1'b0;
    do begin
      @(posedge aclk);
      n++;
      hit = ((z ? zero_event : demag_event) === 1'b1);
    end while (!hit && n < lim);
  endtask
  // closing report
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, enc} = 6'h0;
    {comm_hw, sim_demag, mwin_strobe, pwm_strobe} = 4'h0;
    {awaddr, araddr, wdata, lvl} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL);
    `CHK("ctrl", 32'h0, rd_val)
    rd(ADDR_CFG);
    `CHK("cfg", 32'h7800, rd_val)
    rd(8'h10);
    `CHK("bad rd", RESP_SLVERR, rsp)
    wr(8'h10, 32'h1);
    `CHK("bad wr", RESP_SLVERR, rsp)
    `CHK("comp off", 1'b0, afe.comp_enable)
    $display("test reset done");
    // reference enable and threshold codes
    wr(ADDR_CTRL, 32'h04);
    for (int t = 0; t < 8; t++) begin
      wr(ADDR_CFG, 32'(t << 4));
      repeat (2) @(posedge aclk);
      `CHK("comp on", 1'b1, afe.comp_enable)
      `CHK("ext ref", (t == 7), afe.ext_ref_sel)
      if (t != 7) `CHK("ref", 3'(t), afe.ref_code)
    end
    wr(ADDR_CFG, 32'hA << 7);
    `CHK("rate", 4'hA, mwin_rate)
    $display("test reference done");
    // operating mode from type field and sensor select
    wr(ADDR_CTRL, 32'h02);
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_CFG, 32'(t));
      rd(ADDR_STAT);
      `CHK("mode", (t == 0) ? 3'b010 : 3'b100, rd_val[6:4])
    end
    wr(ADDR_CTRL, 32'h03);
    wr(ADDR_CFG, 32'h0);
    rd(ADDR_STAT);
    `CHK("mode", 3'b001, rd_val[6:4])
    $display("test mode done");
    // speed mode: one selected digital input
    wr(ADDR_CTRL, 32'h02);
    for (int i = 0; i < 3; i++) begin
      enc <= (i < 2);
      lvl <= 3'(1 << i);
      wr(ADDR_CFG, 32'(1 | (i << 2)));
      repeat (8) @(posedge aclk);
      `CHK("mux", 2'(i), afe.mux_sel)
      `CHK("spd hi", 1'b1, speed_input)
      lvl <= 3'h7 ^ 3'(1 << i);
      repeat (8) @(posedge aclk);
      `CHK("spd lo", 1'b0, speed_input)
    end
    // sensor mode: hall pattern
    enc <= 1'b0;
    lvl <= 3'h5;
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CTRL, 32'h03);
    repeat (8) @(posedge aclk);
    `CHK("hall", 3'h5, hall_state)
    $display("test inputs done");
    // sensorless blanking window and event count
    wr(ADDR_CTRL, 32'h02);
    lvl <= 3'h1;
    foreach (codes[j]) begin
      c = codes[j];
      k = c >> 2;
      e = (c < 8) ? (c + 1) * 5 : 60 + (c - 8) * 20;
      wr(ADDR_CFG, 32'((c << 11) | (k << 15)));
      repeat (8) @(posedge aclk);
      pulse(0);
      wait_ev(1'b0, 400);
      `CHK("demag", 1'b1, hit)
      `CHK("blank", 1'b1, n > e)
      `CHK("count", 1'b1, n <= e + k + 8)
    end
    // sensor select: no window, limit zero
    wr(ADDR_CTRL, 32'h03);
    wr(ADDR_CFG, 32'hF << 11 | 32'hF << 15);
    pulse(0);
    wait_ev(1'b0, 400);
    `CHK("no blank", 1'b1, n < 10)
    $display("test window done");
    // simulated demag ignores the count
    wr(ADDR_CTRL, 32'h02);
    wr(ADDR_CFG, 32'hF << 15);
    lvl <= 3'h0;
    pulse(0);
    wait_ev(1'b0, 20);
    `CHK("no demag", 1'b0, hit)
    pulse(1);
    wait_ev(1'b0, 3);
    `CHK("sim demag", 1'b1, hit)
    $display("test simulated done");
    // event order, both polarities, window then pwm strobe
    for (v = 0; v < 2; v++) begin
      wr(ADDR_CTRL, 32'(32'h32 | (v << 3) | (v << 6)));
      wr(ADDR_CFG, 32'h0);
      lvl <= 3'(v);
      repeat (8) @(posedge aclk);
      pulse(0);
      repeat (12) @(posedge aclk);
      pulse(v ? 3 : 2);
      wait_ev(1'b1, 4);
      `CHK("z early", 1'b0, hit)
      lvl <= 3'(!v);
      wait_ev(1'b0, 30);
      `CHK("d level", 1'b1, hit)
      lvl <= 3'(v);
      repeat (8) @(posedge aclk);
      pulse(v ? 3 : 2);
      wait_ev(1'b1, 4);
      `CHK("z after d", 1'b1, hit)
    end
    $display("test order done");
    // status flags, clear commands and software commutation
    rd(ADDR_STAT);
    `CHK("flags", 2'h3, rd_val[1:0])
    wr(ADDR_CMD, 32'hC);
    rd(ADDR_STAT);
    `CHK("flags clr", 2'h0, rd_val[1:0])
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_STAT);
    `CHK("sw blank", 1'b1, rd_val[2])
    // level mode: zero crossing taken on the demag level
    wr(ADDR_CTRL, 32'h82);
    lvl <= 3'h1;
    pulse(0);
    wait_ev(1'b0, 30);
    `CHK("lvl d", 1'b1, hit)
    pulse(2);
    wait_ev(1'b1, 4);
    `CHK("lvl z", 1'b1, hit)
    $display("test status done");
    give_verdict();
  end
endmodule
